//--- bench/spi_far_end.sv
/*
  spi_far_end: behavioural far side, slave to the port's master or master to its slave.
  assumes: line holds the resolved pin levels {ss, sck, mosi, miso}.
*/
`timescale 1ns/10ps
module spi_far_end
(
  // clock
  input  wire logic       sys_clk,
  // resolved lines and format
  input  wire logic [3:0] line,
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  // drive towards the pins
  output logic [3:0]      ext_val,
  output logic [3:0]      ext_en
);
  logic [16:0] tx_q;
  logic [15:0] rx_q;
  logic        m_on;
  logic        m_sck;
  logic        m_ss_b;
  logic        m_mosi;
  initial {tx_q, rx_q, m_on, m_sck, m_mosi, m_ss_b} = 37'h1;
  // select only pulls low; high is left to the pull-up
  assign ext_val = {m_ss_b, m_sck, m_mosi, tx_q[16]};
  assign ext_en  = {~m_ss_b, m_on, m_on, ~m_on};
  // follows each clock-line change at once, so fast rates still meet the master
  always @(line[2])
  begin
    if (!m_on)
    begin
      if ((line[2] != clock_polarity_bit) ^ clock_phase_bit)
        rx_q <= {rx_q[14:0], line[1]};
      else
        tx_q <= {tx_q[15:0], 1'b0};
    end
  end
  task load(input logic [16:0] v);
    tx_q     = v;
    rx_q     = 16'h0000;
  endtask : load
  // phase 0, polarity 0, msb first; select negated after every word
  task send(input logic [7:0] w);
    m_on   = 1'b1;
    rx_q   = 16'h0000;
    // clock settles at idle before select falls and stays driven after, no false edge
    repeat (4) @(negedge sys_clk);
    m_ss_b = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      m_mosi = w[i];
      repeat (4) @(negedge sys_clk);
      m_sck = 1'b1;
      rx_q  = {rx_q[14:0], line[0]};
      repeat (4) @(negedge sys_clk);
      m_sck = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    m_ss_b = 1'b1;
  endtask : send
  task fault_pulse();
    m_ss_b = 1'b0;
    repeat (4) @(negedge sys_clk);
    m_ss_b = 1'b1;
  endtask : fault_pulse
endmodule : spi_far_end

//--- bench/tb_top.sv
/*
  tb_top: self-checking bench for spi_pin_port with a far-side model.
  assumes: released lines are pulled up; inputs change at falling edges.
*/
`timescale 1ns/10ps
module tb_top;
  logic                     sys_clk;
  logic                     rst_b;
  logic                     ctrl_wr;
  logic                     dir_wr;
  logic                     pin_sel_wr;
  logic                     data_wr;
  logic                     data_rd;
  logic                     status_rd;
  spi_pin_pkg::ctrl_type    ctrl_wdata;
  spi_pin_pkg::ctrl_type    ctrl_q;
  spi_pin_pkg::pin_sel_type pin_sel_wdata;
  spi_pin_pkg::pin_sel_type pin_sel_q;
  spi_pin_pkg::status_type  status_q;
  logic [7:0]               dir_wdata;
  logic [7:0]               gpio_out;
  logic [7:0]               dir_q;
  logic [7:0]               pin_o;
  logic [7:0]               pin_oe_b;
  logic [7:0]               pin_level_q;
  logic [7:0]               line_all;
  logic [15:0]              data_wdata;
  logic [15:0]              rx_buf_q;
  logic [15:0]              last_rx;
  logic [5:0]               uart_ctl;
  logic [3:0]               ext_val;
  logic [3:0]               ext_en;
  logic                     irq_q;
  logic                     sck_seen;
  int                       gap_n;
  int                       gap_q;
  int                       miscompares;
  int                       tests_run;

  assign line_all = (~pin_oe_b & pin_o) | (pin_oe_b & ~({4'h0, ext_en} & ~{4'h0, ext_val}));

  spi_pin_port spi_pin_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .dir_wr(dir_wr), .dir_wdata(dir_wdata), .pin_sel_wr(pin_sel_wr),
    .pin_sel_wdata(pin_sel_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rd(data_rd), .status_rd(status_rd), .gpio_out(gpio_out),
    .uart_a_tx_enable(uart_ctl[0]), .uart_a_rx_enable(uart_ctl[1]),
    .uart_b_tx_enable(uart_ctl[2]), .uart_b_rx_enable(uart_ctl[3]),
    .uart_a_tx_bit(uart_ctl[4]), .uart_b_tx_bit(uart_ctl[5]), .ctrl_q(ctrl_q),
    .status_q(status_q), .pin_sel_q(pin_sel_q), .dir_q(dir_q), .rx_buf_q(rx_buf_q),
    .pin_level_q(pin_level_q), .irq_q(irq_q), .pin_i(line_all), .pin_o(pin_o),
    .pin_oe_b(pin_oe_b));

  spi_far_end spi_far_end_inst (.sys_clk(sys_clk), .line(line_all[3:0]), .clock_polarity_bit(ctrl_q.clock_polarity_bit),
    .clock_phase_bit(ctrl_q.clock_phase_bit), .ext_val(ext_val), .ext_en(ext_en));

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // cycles between clock-line changes, to judge the divider
  always @(posedge sys_clk)
  begin
    gap_n    <= gap_n + 1;
    sck_seen <= line_all[2];
    if (line_all[2] !== sck_seen)
    begin
      gap_q <= gap_n;
      gap_n <= 1;
    end
  end

  task tally_and_finish();
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // one-cycle strobe: 0 ctrl, 1 dir, 2 select, 3 data write, 4 data read, 5 status read
  task strobe(input int k);
    @(negedge sys_clk);
    case (k)
      0: ctrl_wr = 1'b1;
      1: dir_wr = 1'b1;
      2: pin_sel_wr = 1'b1;
      3: data_wr = 1'b1;
      4: data_rd = 1'b1;
      default: status_rd = 1'b1;
    endcase
    @(negedge sys_clk);
    {ctrl_wr, dir_wr, pin_sel_wr, data_wr, data_rd, status_rd} = 6'h00;
  endtask : strobe

  // flags: enable, master, wired_or, clock_polarity_bit, clock_phase_bit, size16, lsb_first, irq_en
  task cfg(input logic [7:0] fl, input logic [7:0] dv, input logic [7:0] dr, input logic [2:0] sl);
    ctrl_wdata    = {fl, dv};
    dir_wdata     = dr;
    pin_sel_wdata = sl;
    strobe(0);
    strobe(1);
    strobe(2);
    cyc(2);
  endtask : cfg

  task clear_flags();
    strobe(5);
    strobe(4);
    cyc(1);
    check(16'(status_q), 16'h0000, "flags after clear");
  endtask : clear_flags

  task t_pins();
    gpio_out = 8'ha5;
    cfg(8'h00, 8'h00, 8'hff, 3'h0);
    check(16'(pin_o), 16'h00a5, "gpio drive");
    check(16'(pin_level_q), 16'h00a5, "pin levels");
    check(16'(pin_oe_b), 16'h0000, "all outputs");
    cfg(8'h20, 8'h00, 8'hff, 3'h0);
    check(16'(pin_oe_b), 16'h0005, "open drain");
    uart_ctl = 6'h01;
    cyc(3);
    check(16'(pin_o[7]), 16'h0000, "uart tx pin");
    uart_ctl = 6'h00;
    gpio_out = 8'h5a;
  endtask : t_pins

  task xfer(input logic pol, pha, sz, lsb, input logic [7:0] dv, input logic [15:0] w, pw,
            input logic col, ovr, clr);
    logic [15:0] pw16;
    logic [15:0] r16;
    logic [7:0]  r8;
    logic [15:0] exp_tx;
    cfg({3'b110, pol, pha, sz, lsb, 1'b1}, dv, 8'h06, 3'h7);
    pw16 = sz ? pw : {pw[7:0], 8'h00};
    spi_far_end_inst.load(pha ? {1'b0, pw16} : {pw16, 1'b0});
    check(16'(line_all[2]), 16'(pol), "idle clock");
    data_wdata = w;
    strobe(3);
    if (col)
    begin
      cyc(4);
      data_wdata = ~w;
      strobe(3);
      cyc(1);
      check(16'(status_q.write_collision_flag), 16'h0001, "collision flag");
    end
    cyc((sz ? 32 : 16) * dv + 6);
    check(16'(status_q.transfer_complete_flag), 16'h0001, "complete flag");
    check(16'(irq_q), 16'h0001, "irq");
    check(16'(gap_q), 16'(dv), "half period");
    r16 = {<<{w}};
    r8  = {<<{w[7:0]}};
    exp_tx = sz ? (lsb ? r16 : w) : {8'h00, lsb ? r8 : w[7:0]};
    check(sz ? spi_far_end_inst.rx_q : {8'h00, spi_far_end_inst.rx_q[7:0]}, exp_tx,
          "sent word");
    r16 = {<<{pw}};
    r8  = {<<{pw[7:0]}};
    if (!ovr)
      last_rx = sz ? (lsb ? r16 : pw) : {8'h00, lsb ? r8 : pw[7:0]};
    check(rx_buf_q, last_rx, "received word");
    if (clr)
      clear_flags();
  endtask : xfer

  task t_slave();
    cfg(8'h80, 8'h00, 8'h01, 3'h7);
    data_wdata = 16'h003c;
    strobe(3);
    spi_far_end_inst.send(8'h96);
    cyc(2);
    check(rx_buf_q, 16'h0096, "slave receive");
    check(16'(status_q.transfer_complete_flag), 16'h0001, "slave complete");
    check({8'h00, spi_far_end_inst.rx_q[7:0]}, 16'h003c, "slave send");
    clear_flags();
  endtask : t_slave

  task t_fault();
    cfg(8'hc0, 8'h03, 8'h06, 3'h7);
    spi_far_end_inst.fault_pulse();
    cyc(3);
    check(16'(status_q.mode_fault_flag), 16'h0001, "fault flag");
    check(16'({ctrl_q.enable, ctrl_q.master}), 16'h0000, "fault control");
    check(16'(dir_q), 16'h0000, "fault direction");
    check(16'(pin_oe_b[2:0]), 16'h0007, "drivers off");
    check(16'(pin_sel_q), 16'h0007, "pin select kept");
    strobe(5);
    ctrl_wdata = 16'h0000;
    strobe(0);
    cyc(1);
    check(16'(status_q.mode_fault_flag), 16'h0000, "fault clear");
  endtask : t_fault

  initial
  begin
    {ctrl_wr, dir_wr, pin_sel_wr, data_wr, data_rd, status_rd} = 6'h00;
    {ctrl_wdata, pin_sel_wdata, dir_wdata, gpio_out, data_wdata, uart_ctl} = 57'h0;
    {rst_b, miscompares, tests_run, gap_n, gap_q, sck_seen, last_rx} = 0;
    cyc(10);
    rst_b = 1'b1;
    cyc(1);
    check(16'(ctrl_q), 16'h0000, "control reset");
    check(16'({status_q, irq_q}), 16'h0000, "status reset");
    check(16'(pin_oe_b), 16'h00ff, "pins released");
    t_pins();
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h03, 16'h00a7, 16'h005c, 1'b1, 1'b0, 1'b1);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h02, 16'h0031, 16'h00e8, 1'b0, 1'b0, 1'b1);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h04, 16'h00c6, 16'h0093, 1'b0, 1'b0, 1'b1);
    xfer(1'b1, 1'b1, 1'b0, 1'b1, 8'h03, 16'h0071, 16'h00b4, 1'b0, 1'b0, 1'b1);
    xfer(1'b0, 1'b0, 1'b1, 1'b1, 8'h02, 16'hc35a, 16'h1e2d, 1'b0, 1'b0, 1'b1);
    xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h02, 16'h8421, 16'h6b0f, 1'b0, 1'b0, 1'b0);
    xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h02, 16'h1248, 16'hd2e1, 1'b0, 1'b1, 1'b1);
    t_slave();
    t_fault();
    tally_and_finish();
  end

  // the whole sequence takes under a thousand cycles; this is far beyond it
  initial
  begin
    #(100000 * 40);
    miscompares++;
    tally_and_finish();
  end
endmodule : tb_top

//--- rtl/spi_pin_cell.sv
/*
  spi_pin_cell: one port pin, choosing serial or general-purpose drive.
  assumes: the pad resolves the wire from pin_o_q and the active-low enable.
*/
`timescale 1ns/10ps
module spi_pin_cell
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // selection
  input  wire logic use_func,
  input  wire logic func_val,
  input  wire logic func_en,
  input  wire logic gpio_val,
  input  wire logic dir_out,
  input  wire logic open_drain,
  // pad side
  output logic      pin_o_q,
  output logic      pin_oe_b_q
);

  logic val;
  logic drive;

  always_comb
  begin
    val   = use_func ? func_val : gpio_val;
    drive = dir_out & (use_func ? func_en : 1'b1);
  end

  // open drain releases the pin instead of driving a one
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_o_q    <= 1'b0;
      pin_oe_b_q <= 1'b1;
    end
    else
    begin
      pin_o_q    <= val;
      pin_oe_b_q <= !(drive && !(open_drain && val));
    end
  end

endmodule : spi_pin_cell

//--- rtl/spi_pin_pkg.sv
/*
  spi_pin_pkg: shared types and constants for the serial port with shared pin logic.
  assumes: one system clock, all users refer to names as spi_pin_pkg::name.
*/
package spi_pin_pkg;

  // pin positions on the eight-pin port
  localparam logic [2:0] PIN_MISO = 3'h0;
  localparam logic [2:0] PIN_MOSI = 3'h1;
  localparam logic [2:0] PIN_SCK  = 3'h2;
  localparam logic [2:0] PIN_SS   = 3'h3;
  localparam logic [2:0] PIN_RXB  = 3'h4;
  localparam logic [2:0] PIN_TXB  = 3'h5;
  localparam logic [2:0] PIN_RXA  = 3'h6;
  localparam logic [2:0] PIN_TXA  = 3'h7;
  localparam int         NUM_PINS     = 8;
  localparam int         NUM_SPI_PINS = 4;

  // word and edge counts
  localparam int         WORD_W      = 16;
  localparam logic [4:0] LAST_EDGE_8  = 5'h0f;
  localparam logic [4:0] LAST_EDGE_16 = 5'h1f;
  localparam logic [7:0] DIV_MIN      = 8'h02;

  typedef struct packed {
    logic       enable;
    logic       master;
    logic       wired_or;
    logic       clock_polarity_bit;
    logic       clock_phase_bit;
    logic       size16;
    logic       lsb_first;
    logic       irq_en;
    logic [7:0] divider;
  } ctrl_type;

  typedef struct packed {
    logic mode_fault_flag;
    logic write_collision_flag;
    logic transfer_complete_flag;
  } status_type;

  typedef struct packed {
    logic ss;
    logic mosi;
    logic miso;
  } pin_sel_type;

  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [2:0]  STATUS_RST  = 3'h0;
  localparam logic [2:0]  PIN_SEL_RST = 3'h0;
  localparam logic [7:0]  DIR_RST     = 8'h00;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam logic [2:0]  DIR_FAULT_CLR = 3'h0;

endpackage : spi_pin_pkg

//--- rtl/spi_pin_port.sv
/*
  spi_pin_port: serial port (master or slave) with its eight shared port pins.
  assumes: pin inputs are synchronous to sys_clk; software access arrives as
  one-cycle strobes; uart channels outside supply enables and transmit bits.
*/
// Summary of operation
// - select register picks serial or gpio use for mosi, miso and slave select
// - clock pin belongs to the port whenever the port is enabled
// - uart pins become serial pins while their channel enable is set
// - eight direction bits set each pin input or output, any function
// - data shifts out and in together, timed by the serial clock
// - word length 8 or 16 bits, msb or lsb first
// - master makes clock at 254 rates; rate ignored in slave mode
// - writing data during a transfer is flagged as a collision
// - mode fault switches the miso, mosi and clock output drivers off
// - control register readable and writable at any time
// - only hardware sets status bits; software only reads them
// - master data write starts the next transfer
// - complete flag set after every word, master or slave
// - data reads come from buffer; word lost if flag still set
// - transmit data goes straight to the shift register
// - wired-or bit makes the four spi pins open drain, serial or gpio
// - pin roles of miso, mosi, clock, select follow master or slave
// - master ignores external transfers; select low is a mode fault
// - interrupt request while irq_en set and complete or mode fault flag set
// - flag clears by status read then data read or write
// - slave starts when select low, shifts on external clock
// - polarity sets idle level, phase picks format; both ends match
// - master clock is sys_clk over twice rate; zero or one stops it
// - collision leaves transfer alone, data dropped, flag set, no interrupt
// - fault clears master and enable, sets flag, makes miso, mosi and clock pins inputs
`timescale 1ns/10ps
module spi_pin_port
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  // software strobes and write data
  input  wire logic                     ctrl_wr,
  input  wire spi_pin_pkg::ctrl_type    ctrl_wdata,
  input  wire logic                     dir_wr,
  input  wire logic [7:0]               dir_wdata,
  input  wire logic                     pin_sel_wr,
  input  wire spi_pin_pkg::pin_sel_type pin_sel_wdata,
  input  wire logic                     data_wr,
  input  wire logic [15:0]              data_wdata,
  input  wire logic                     data_rd,
  input  wire logic                     status_rd,
  input  wire logic [7:0]               gpio_out,
  // uart channel side
  input  wire logic                     uart_a_tx_enable,
  input  wire logic                     uart_a_rx_enable,
  input  wire logic                     uart_b_tx_enable,
  input  wire logic                     uart_b_rx_enable,
  input  wire logic                     uart_a_tx_bit,
  input  wire logic                     uart_b_tx_bit,
  // register contents
  output spi_pin_pkg::ctrl_type         ctrl_q,
  output spi_pin_pkg::status_type       status_q,
  output spi_pin_pkg::pin_sel_type      pin_sel_q,
  output logic [7:0]                    dir_q,
  output logic [15:0]                   rx_buf_q,
  output logic [7:0]                    pin_level_q,
  output logic                          irq_q,
  // port pins
  input  wire logic [7:0]               pin_i,
  output logic [7:0]                    pin_o,
  output logic [7:0]                    pin_oe_b
);

  logic [15:0] sr_q;
  logic [4:0]  edge_q;
  logic        busy_q;
  logic        slave_busy_q;
  logic        sck_lvl_q;
  logic        sck_prev_q;
  logic        latch_q;
  logic        armed_q;
  logic        mode_fault_flag_armed_q;
  logic        tick;

  logic        master_on;
  logic        ss_low;
  logic        slave_sel;
  logic        din;
  logic        edge_ev;
  logic        sample;
  logic        shift_ev;
  logic        done;
  logic        in_prog;
  logic        fault;
  logic        start;
  logic        flag_clr;
  logic        shift_bit;
  logic [4:0]  last_edge;
  logic [15:0] sr_shift;
  logic        out_bit;
  logic        sck_val;
  logic [7:0]  use_func;
  logic [7:0]  func_val;
  logic [7:0]  func_en;

  spi_rate_div u_rate_div
  (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (busy_q),
    .div     (ctrl_q.divider),
    .tick_q  (tick)
  );

  always_comb
  begin
    master_on = ctrl_q.enable & ctrl_q.master;
    // a select pin left to gpio never selects the slave
    ss_low    = pin_sel_q.ss & !pin_i[spi_pin_pkg::PIN_SS];
    slave_sel = ctrl_q.enable & !ctrl_q.master & ss_low;
    fault     = master_on & ss_low;
    din       = ctrl_q.master ? pin_i[spi_pin_pkg::PIN_MISO]
                              : pin_i[spi_pin_pkg::PIN_MOSI];
    // master ticks on its own divider; slave follows any clock pin change
    edge_ev   = master_on ? (busy_q & tick)
                          : (slave_sel & (pin_i[spi_pin_pkg::PIN_SCK] != sck_prev_q));
    last_edge = ctrl_q.size16 ? spi_pin_pkg::LAST_EDGE_16 : spi_pin_pkg::LAST_EDGE_8;
    sample    = (edge_q[0] == ctrl_q.clock_phase_bit);
    shift_ev  = edge_ev & !sample & !(ctrl_q.clock_phase_bit & (edge_q == 5'h00));
    done      = edge_ev & (edge_q == last_edge);
    shift_bit = sample ? din : latch_q;
    // a slave with phase zero is busy for as long as it is selected
    in_prog   = busy_q | slave_busy_q | (slave_sel & !ctrl_q.clock_phase_bit);
    start     = data_wr & !in_prog & master_on;
    flag_clr  = armed_q & (data_rd | data_wr);
    out_bit   = ctrl_q.lsb_first ? sr_q[0]
                                 : (ctrl_q.size16 ? sr_q[15] : sr_q[7]);
    sck_val   = ctrl_q.clock_polarity_bit ^ sck_lvl_q;
  end

  // shift toward the output end; 8-bit words keep the upper byte clear
  always_comb
  begin
    if (ctrl_q.lsb_first && ctrl_q.size16)
      sr_shift = {shift_bit, sr_q[15:1]};
    else if (ctrl_q.lsb_first)
      sr_shift = {8'h00, shift_bit, sr_q[7:1]};
    else if (ctrl_q.size16)
      sr_shift = {sr_q[14:0], shift_bit};
    else
      sr_shift = {8'h00, sr_q[6:0], shift_bit};
  end

  // shift register: loaded straight from a data write, no transmit buffer
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sr_q <= spi_pin_pkg::WORD_RST;
    else if (data_wr && !in_prog)
      sr_q <= data_wdata;
    else if (shift_ev)
      sr_q <= sr_shift;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      latch_q <= 1'b0;
    else if (edge_ev && sample)
      latch_q <= din;
  end

  // edge count restarts per word; a slave deselected mid-word drops it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      edge_q <= 5'h00;
    else if (start || done || (!ctrl_q.master && !slave_sel))
      edge_q <= 5'h00;
    else if (edge_ev)
      edge_q <= edge_q + 5'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      busy_q <= 1'b0;
    else if (start)
      busy_q <= 1'b1;
    else if (done || fault || !master_on)
      busy_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      slave_busy_q <= 1'b0;
    else if (done || !slave_sel)
      slave_busy_q <= 1'b0;
    else if (edge_ev && !ctrl_q.master)
      slave_busy_q <= 1'b1;
  end

  // master clock: toggles per tick, back to idle between words
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sck_lvl_q <= 1'b0;
    else if (!busy_q || start || fault || !master_on)
      sck_lvl_q <= 1'b0;
    else if (edge_ev)
      sck_lvl_q <= !sck_lvl_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sck_prev_q <= 1'b0;
    else
      sck_prev_q <= pin_i[spi_pin_pkg::PIN_SCK];
  end

  // receive buffer: a finished word is dropped while the flag still stands
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rx_buf_q <= spi_pin_pkg::WORD_RST;
    else if (done && !status_q.transfer_complete_flag)
      rx_buf_q <= sr_shift;
  end

  // clearing sequences: status read arms, next data or control access clears
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      armed_q <= 1'b0;
    else if (status_rd && (status_q.transfer_complete_flag || status_q.write_collision_flag))
      armed_q <= 1'b1;
    else if (data_rd || data_wr)
      armed_q <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_fault_flag_armed_q <= 1'b0;
    else if (status_rd && status_q.mode_fault_flag)
      mode_fault_flag_armed_q <= 1'b1;
    else if (ctrl_wr)
      mode_fault_flag_armed_q <= 1'b0;
  end

  // status flags: hardware events only, and a set beats a clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      status_q <= spi_pin_pkg::status_type'(spi_pin_pkg::STATUS_RST);
    else
    begin
      if (done)
        status_q.transfer_complete_flag <= 1'b1;
      else if (flag_clr)
        status_q.transfer_complete_flag <= 1'b0;
      if (data_wr && in_prog)
        status_q.write_collision_flag <= 1'b1;
      else if (flag_clr)
        status_q.write_collision_flag <= 1'b0;
      if (fault)
        status_q.mode_fault_flag <= 1'b1;
      else if (mode_fault_flag_armed_q && ctrl_wr)
        status_q.mode_fault_flag <= 1'b0;
    end
  end

  // control: always writable; enable and master stay low while a fault stands
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_q <= spi_pin_pkg::ctrl_type'(spi_pin_pkg::CTRL_RST);
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_q <= ctrl_wdata;
        if (status_q.mode_fault_flag && !mode_fault_flag_armed_q)
        begin
          ctrl_q.enable <= 1'b0;
          ctrl_q.master <= 1'b0;
        end
      end
      if (fault)
      begin
        ctrl_q.enable <= 1'b0;
        ctrl_q.master <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      dir_q <= spi_pin_pkg::DIR_RST;
    else
    begin
      if (dir_wr)
        dir_q <= dir_wdata;
      if (fault)
        dir_q[2:0] <= spi_pin_pkg::DIR_FAULT_CLR;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pin_sel_q <= spi_pin_pkg::pin_sel_type'(spi_pin_pkg::PIN_SEL_RST);
    else if (pin_sel_wr)
      pin_sel_q <= pin_sel_wdata;
  end

  // write_collision_flag deliberately raises no request
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= ctrl_q.irq_en & (status_q.transfer_complete_flag | status_q.mode_fault_flag);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pin_level_q <= 8'h00;
    else
      pin_level_q <= pin_i;
  end

  // pin function, value and serial-side drive permission
  always_comb
  begin
    use_func = {uart_a_tx_enable, uart_a_rx_enable, uart_b_tx_enable, uart_b_rx_enable,
                pin_sel_q.ss, ctrl_q.enable, pin_sel_q.mosi, pin_sel_q.miso};
    func_val = {uart_a_tx_bit, gpio_out[6], uart_b_tx_bit, gpio_out[4],
                1'b1, sck_val, out_bit, out_bit};
    // select is input only; clock and mosi drive as master, miso as selected slave
    func_en  = {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, ctrl_q.master, ctrl_q.master,
                !ctrl_q.master & ss_low};
  end

  for (genvar i = 0; i < spi_pin_pkg::NUM_PINS; i++)
  begin : g_pin
    spi_pin_cell u_cell
    (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .use_func   (use_func[i]),
      .func_val   (func_val[i]),
      .func_en    (func_en[i]),
      .gpio_val   (gpio_out[i]),
      .dir_out    (dir_q[i]),
      .open_drain (ctrl_q.wired_or && (i < spi_pin_pkg::NUM_SPI_PINS)),
      .pin_o_q    (pin_o[i]),
      .pin_oe_b_q (pin_oe_b[i])
    );
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  property p_fault;
    fault |=> !ctrl_q.enable && !ctrl_q.master && status_q.mode_fault_flag && (dir_q[2:0] == 3'h0);
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not handled");

  property p_fault_drivers;
    fault |=> ##1 (pin_oe_b[2:0] == 3'h7);
  endproperty
  a_fault_drivers: assert property (p_fault_drivers) else $error("drivers on after fault");

  property p_write_collision_flag;
    data_wr && in_prog |=> status_q.write_collision_flag && (busy_q == $past(busy_q) || $past(done));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_transfer_complete_flag;
    $rose(status_q.transfer_complete_flag) |-> $past(done);
  endproperty
  a_transfer_complete_flag: assert property (p_transfer_complete_flag) else $error("complete flag without a word");

  property p_overrun;
    done && status_q.transfer_complete_flag |=> rx_buf_q == $past(rx_buf_q);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun overwrote buffer");

  property p_irq;
    status_q.transfer_complete_flag && ctrl_q.irq_en |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("no request on complete");

  property p_clear;
    status_rd && status_q.transfer_complete_flag ##1 !(data_rd || data_wr) ##1 (data_rd && !done)
      |=> !status_q.transfer_complete_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_start;
    start |=> busy_q && (edge_q == 5'h00) && (sr_q == $past(data_wdata));
  endproperty
  a_start: assert property (p_start) else $error("master write did not start");

  property p_idle;
    !busy_q |-> sck_val == ctrl_q.clock_polarity_bit;
  endproperty
  a_idle: assert property (p_idle) else $error("clock not idle");

  property p_stopped;
    (ctrl_q.divider < 8'h02) [*2] |-> !tick;
  endproperty
  a_stopped: assert property (p_stopped) else $error("clock runs at rate below two");

endmodule : spi_pin_port

//--- rtl/spi_rate_div.sv
/*
  spi_rate_div: half-period tick generator for the master serial clock.
  assumes: div is stable during a transfer; values below two stop the ticks.
*/
`timescale 1ns/10ps
module spi_rate_div
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       run,
  input  wire logic [7:0] div,
  // half-period pulse
  output logic            tick_q
);

  logic [7:0] count_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_q <= 8'h00;
      tick_q  <= 1'b0;
    end
    else if (!run || div < spi_pin_pkg::DIV_MIN)
    begin
      count_q <= 8'h00;
      tick_q  <= 1'b0;
    end
    else if (count_q == div - 8'h01)
    begin
      count_q <= 8'h00;
      tick_q  <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 8'h01;
      tick_q  <= 1'b0;
    end
  end

endmodule : spi_rate_div
